/* hw/vpwph_regs.svh */
// Constants for the VPW bus protocol handler: offsets, fields, codes, times.
// Assumes a 50 MHz pclk and an APB register port with 12-bit byte addresses.
`ifndef VPWPH_REGS_SVH
`define VPWPH_REGS_SVH
`define VPWPH_CLK_MHZ      50
`define VPWPH_T_A_US       34
`define VPWPH_T_B_US       96
`define VPWPH_T_C_US       163
`define VPWPH_T_D_US       239
`define VPWPH_T_E_US       280
`define VPWPH_T_IDLE_US    300
`define VPWPH_T_SHORT_US   64
`define VPWPH_T_LONG_US    128
`define VPWPH_T_SOF_US     200
`define VPWPH_T_LOOP_US    16
`define VPWPH_OFS_CTRL1    12'h000
`define VPWPH_OFS_CTRL2    12'h004
`define VPWPH_OFS_CODE     12'h008
`define VPWPH_OFS_DATA     12'h00C
`define VPWPH_OFS_STATUS   12'h010
`define VPWPH_CTRL1_IRQ    0
`define VPWPH_CTRL2_LOOP   0
`define VPWPH_CTRL2_X4     1
`define VPWPH_DATA_LAST    8
`define VPWPH_CODE_SYM     8'h1C
`define VPWPH_CODE_CRC     8'h18
`define VPWPH_CODE_LOSS    8'h14
`define VPWPH_CODE_RXFULL  8'h0C
`define VPWPH_CODE_TXEMPTY 8'h08
`define VPWPH_CODE_NONE    8'h00
`define VPWPH_CRC_INIT     8'hFF
`define VPWPH_CRC_POLY     8'h1D
`define VPWPH_CRC_RESIDUE  8'hC4
`endif

/* hw/vpwph_pkg.sv */
// Types of the VPW bus protocol handler.
// Constants live in vpwph_regs.svh.
package vpwph_pkg;
  typedef enum logic [4:0] {
    VPWPH_TX_OFF   = 5'b00001,
    VPWPH_TX_DEFER = 5'b00010,
    VPWPH_TX_SOF   = 5'b00100,
    VPWPH_TX_BIT   = 5'b01000,
    VPWPH_TX_HOLD  = 5'b10000
  } vpwph_tx_e;
  typedef struct packed {
    logic        irq_allow;
    logic        loopback_select;
    logic        fourfold_receive_allow;
    logic [7:0]  tx_hold;
    logic        hold_last;
    logic        tx_holding_empty_flag;
    logic [7:0]  rx_hold;
    logic        rx_byte_full_flag;
    logic        err_sym;
    logic        err_crc;
    logic        err_loss;
    logic        rx_prev;
    logic [15:0] rx_cnt;
    logic        in_frame;
    logic [2:0]  rx_bits;
    logic [7:0]  rx_shift;
    logic [7:0]  rx_crc;
    vpwph_tx_e   tx_st;
    logic        tx_pin;
    logic        tx_lvl;
    logic [15:0] tx_cnt;
    logic [2:0]  tx_bits;
    logic [7:0]  tx_shift;
    logic        tx_last;
    logic        tx_crc_out;
    logic [7:0]  tx_crc;
    logic [1:0]  append_left;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        irq;
  } vpwph_state_s;
endpackage

/* hw/vpwph_top.sv */
// VPW single-wire bus protocol handler with an APB register port.
// Assumes an external transceiver: bus_tx_pin high drives the bus active,
// bus_rx_pin high means the bus is active; both synchronous to pclk.
// Functional notes
// - Active bit ending before threshold a: invalid
// - Active end between a and b: logic 1
// - Active end between b and c: logic 0
// - Active end between c and d: SOF
// - Active beyond break threshold: BREAK
// - Pending transmit waits for idle bus
// - Arbitration starts at first bit after SOF
// - Logic 0 dominates logic 1
// - Dominant seen while sending recessive: stop
// - Eighth-bit loss appends up to two ones
// - Second one dropped if first loses
// - Full byte to holding, flag, interrupt
// - Shifter reloads from holding, sets empty
// - Loopback selects own transmit as receive
// - Never transmit fourfold; receive when allowed
// - Fourfold traffic is noise unless allowed
// - Block mode: no frame length limit
// - Own invalid bits or framing: abort, code
// - Receive CRC residue mismatch flags error
// - Data bits are 64 or 128 us
// - SOF is 200 us active
// - BREAK is at least 240 us active
// - Symbol timing resolution is one pclk
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "vpwph_regs.svh"
`default_nettype none

module vpwph_top #(
  parameter logic [15:0] TA_CYC    = 16'(`VPWPH_T_A_US * `VPWPH_CLK_MHZ),
  parameter logic [15:0] TB_CYC    = 16'(`VPWPH_T_B_US * `VPWPH_CLK_MHZ),
  parameter logic [15:0] TC_CYC    = 16'(`VPWPH_T_C_US * `VPWPH_CLK_MHZ),
  parameter logic [15:0] TD_CYC    = 16'(`VPWPH_T_D_US * `VPWPH_CLK_MHZ),
  parameter logic [15:0] TE_CYC    = 16'(`VPWPH_T_E_US * `VPWPH_CLK_MHZ),
  parameter logic [15:0] IDLE_CYC  = 16'(`VPWPH_T_IDLE_US * `VPWPH_CLK_MHZ),
  parameter logic [15:0] SHORT_CYC = 16'(`VPWPH_T_SHORT_US * `VPWPH_CLK_MHZ),
  parameter logic [15:0] LONG_CYC  = 16'(`VPWPH_T_LONG_US * `VPWPH_CLK_MHZ),
  parameter logic [15:0] SOF_CYC   = 16'(`VPWPH_T_SOF_US * `VPWPH_CLK_MHZ),
  parameter logic [15:0] LOOP_CYC  = 16'(`VPWPH_T_LOOP_US * `VPWPH_CLK_MHZ)
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        bus_rx_pin,
  output logic             bus_tx_pin,
  output logic             irq
);

  vpwph_pkg::vpwph_state_s s_q;
  vpwph_pkg::vpwph_state_s s_d;

  // ----------------------------------------
  // Receive decode
  // ----------------------------------------
  logic        rx_line;
  logic        edge_s;
  logic        fall_s;
  logic        rise_s;
  logic [15:0] ta_t;
  logic [15:0] tb_t;
  logic [15:0] tc_t;
  logic [15:0] td_t;
  logic [15:0] te_t;
  logic        lt_a;
  logic        lt_b;
  logic        lt_c;
  logic        lt_d;
  logic        bit_evt;
  logic        bit_val;
  logic        sof_evt;
  logic        bad_evt;
  logic        eod_evt;
  logic        brk_evt;
  logic        bus_idle;
  logic        byte_done;
  logic [7:0]  rx_next_byte;

  assign rx_line = s_q.loopback_select ? s_q.tx_pin : bus_rx_pin;
  assign edge_s  = rx_line ^ s_q.rx_prev;
  assign fall_s  = edge_s & s_q.rx_prev;
  assign rise_s  = edge_s & ~s_q.rx_prev;

  // Quartered windows; unscaled fourfold bits fall below a as noise
  assign ta_t = s_q.fourfold_receive_allow ? (TA_CYC >> 2) : TA_CYC;
  assign tb_t = s_q.fourfold_receive_allow ? (TB_CYC >> 2) : TB_CYC;
  assign tc_t = s_q.fourfold_receive_allow ? (TC_CYC >> 2) : TC_CYC;
  assign td_t = s_q.fourfold_receive_allow ? (TD_CYC >> 2) : TD_CYC;
  assign te_t = s_q.fourfold_receive_allow ? (TE_CYC >> 2) : TE_CYC;

  assign lt_a = s_q.rx_cnt < ta_t;
  assign lt_b = s_q.rx_cnt < tb_t;
  assign lt_c = s_q.rx_cnt < tc_t;
  assign lt_d = s_q.rx_cnt < td_t;

  assign bit_evt = edge_s & ~lt_a & lt_c;
  assign bit_val = fall_s ? lt_b : ~lt_b;
  assign sof_evt = fall_s & ~lt_c & lt_d;
  assign bad_evt = (edge_s & lt_a) | (fall_s & ~lt_d);
  assign eod_evt = ~s_q.rx_prev & (s_q.rx_cnt == tc_t);
  assign brk_evt = s_q.rx_prev & (s_q.rx_cnt == te_t);
  assign bus_idle = ~s_q.rx_prev & (s_q.rx_cnt >= IDLE_CYC);
  assign byte_done = s_q.in_frame & bit_evt & ~sof_evt & ~bad_evt
                   & (s_q.rx_bits == 3'd7);
  assign rx_next_byte = {s_q.rx_shift[6:0], bit_val};

  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
    logic fb;
    fb = c[7] ^ b;
    crc_step = {c[6:0], 1'b0} ^ (fb ? `VPWPH_CRC_POLY : 8'h00);
  endfunction

  // ----------------------------------------
  // Transmit helpers
  // ----------------------------------------
  logic        tx_on;
  logic        tx_val;
  logic [15:0] tx_dur;
  logic        mismatch;
  logic        eighth;
  logic        tx_err;
  logic        tx_reload;
  logic [7:0]  tx_crc_next;
  logic [7:0]  code_v;
  logic        access;
  logic        done;
  logic        unmapped;
  logic [31:0] rdval;

  assign tx_on  = (s_q.tx_st == vpwph_pkg::VPWPH_TX_SOF) | (s_q.tx_st == vpwph_pkg::VPWPH_TX_BIT);
  assign tx_val = (s_q.append_left != 2'd0) ? 1'b1 : s_q.tx_shift[7];
  // Durations never scale: no fourfold transmit
  assign tx_dur = (tx_val ^ s_q.tx_lvl) ? LONG_CYC : SHORT_CYC;
  // Compared only in bit phase, after loop delay; a 0 overrides our 1
  assign mismatch = (s_q.tx_st == vpwph_pkg::VPWPH_TX_BIT) & (s_q.tx_cnt >= LOOP_CYC)
                  & (rx_line != s_q.tx_pin);
  assign eighth = (s_q.tx_bits == 3'd7) & (s_q.append_left == 2'd0);
  assign tx_err = tx_on & s_q.in_frame
                & (bad_evt | (eod_evt & (s_q.rx_bits != 3'd0)));
  assign tx_crc_next = crc_step(s_q.tx_crc, tx_val);
  assign tx_reload = (s_q.tx_st == vpwph_pkg::VPWPH_TX_BIT) & ~mismatch & ~tx_err
                   & (s_q.append_left == 2'd0) & (s_q.tx_cnt == tx_dur - 16'h0001)
                   & (s_q.tx_bits == 3'd7) & ~s_q.tx_crc_out & ~s_q.tx_last
                   & ~s_q.tx_holding_empty_flag;

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  assign access = psel & penable;
  assign done   = access & s_q.pready;

  always_comb begin
    if (s_q.err_sym) begin
      code_v = `VPWPH_CODE_SYM;
    end else if (s_q.err_crc) begin
      code_v = `VPWPH_CODE_CRC;
    end else if (s_q.err_loss) begin
      code_v = `VPWPH_CODE_LOSS;
    end else if (s_q.rx_byte_full_flag) begin
      code_v = `VPWPH_CODE_RXFULL;
    end else if (s_q.tx_holding_empty_flag) begin
      code_v = `VPWPH_CODE_TXEMPTY;
    end else begin
      code_v = `VPWPH_CODE_NONE;
    end
    unmapped = 1'b0;
    rdval    = 32'h0000_0000;
    case (paddr)
      `VPWPH_OFS_CTRL1: rdval[`VPWPH_CTRL1_IRQ] = s_q.irq_allow;
      `VPWPH_OFS_CTRL2: begin
        rdval[`VPWPH_CTRL2_LOOP] = s_q.loopback_select;
        rdval[`VPWPH_CTRL2_X4]   = s_q.fourfold_receive_allow;
      end
      `VPWPH_OFS_CODE:   rdval[7:0] = code_v;
      `VPWPH_OFS_DATA:   rdval[7:0] = s_q.rx_hold;
      `VPWPH_OFS_STATUS: rdval[7:0] = {~tx_on, bus_idle, s_q.in_frame, s_q.err_sym,
                                       s_q.err_crc, s_q.err_loss,
                                       s_q.tx_holding_empty_flag, s_q.rx_byte_full_flag};
      default: unmapped = 1'b1;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    // Bus answer: one wait state, then pready with data
    s_d.pready  = access & ~s_q.pready;
    s_d.pslverr = (access & ~s_q.pready) ? unmapped : 1'b0;
    s_d.prdata  = (access & ~s_q.pready) ? rdval : 32'h0000_0000;
    // Clears first, so a same-cycle hardware set wins below
    if (done && !s_q.pslverr) begin
      if (pwrite) begin
        case (paddr)
          `VPWPH_OFS_CTRL1: s_d.irq_allow = pwdata[`VPWPH_CTRL1_IRQ];
          `VPWPH_OFS_CTRL2: begin
            s_d.loopback_select        = pwdata[`VPWPH_CTRL2_LOOP];
            s_d.fourfold_receive_allow = pwdata[`VPWPH_CTRL2_X4];
          end
          `VPWPH_OFS_DATA: begin
            s_d.tx_hold               = pwdata[7:0];
            s_d.hold_last             = pwdata[`VPWPH_DATA_LAST];
            s_d.tx_holding_empty_flag = 1'b0;
          end
          default: s_d.irq_allow = s_q.irq_allow;
        endcase
      end else if (paddr == `VPWPH_OFS_DATA) begin
        s_d.rx_byte_full_flag = 1'b0;
      end else if (paddr == `VPWPH_OFS_CODE) begin
        // Reading the code drops the error shown; a shown RXFULL or TXEMPTY stays set
        if (s_q.err_sym) begin
          s_d.err_sym = 1'b0;
        end else if (s_q.err_crc) begin
          s_d.err_crc = 1'b0;
        end else begin
          s_d.err_loss = 1'b0;
        end
      end
    end

    // Receiver: symbol timer counts pclk periods since the last edge
    s_d.rx_prev = rx_line;
    s_d.rx_cnt  = edge_s ? 16'h0000 : ((&s_q.rx_cnt) ? s_q.rx_cnt : s_q.rx_cnt + 16'h0001);
    if (sof_evt) begin
      s_d.in_frame = 1'b1;
      s_d.rx_bits  = 3'd0;
      s_d.rx_crc   = `VPWPH_CRC_INIT;
    end else if (s_q.in_frame) begin
      if (bad_evt || brk_evt) begin
        s_d.in_frame = 1'b0;
        s_d.err_sym  = 1'b1;
      end else if (bit_evt) begin
        // No byte counter: frames run as long as bits keep coming
        s_d.rx_shift = rx_next_byte;
        s_d.rx_crc   = crc_step(s_q.rx_crc, bit_val);
        s_d.rx_bits  = s_q.rx_bits + 3'd1;
        if (byte_done) begin
          s_d.rx_hold           = rx_next_byte;
          s_d.rx_byte_full_flag = 1'b1;
        end
      end else if (eod_evt) begin
        s_d.in_frame = 1'b0;
        if (s_q.rx_bits != 3'd0) begin
          s_d.err_sym = 1'b1;
        end else if (s_q.rx_crc != `VPWPH_CRC_RESIDUE) begin
          s_d.err_crc = 1'b1;
        end
      end
    end

    // Transmitter
    s_d.tx_cnt = s_q.tx_cnt + 16'h0001;
    case (s_q.tx_st)
      vpwph_pkg::VPWPH_TX_OFF: begin
        s_d.tx_pin = 1'b0;
        if (!s_q.tx_holding_empty_flag) begin
          s_d.tx_st = vpwph_pkg::VPWPH_TX_DEFER;
        end
      end
      vpwph_pkg::VPWPH_TX_DEFER: begin
        if (bus_idle) begin
          s_d.tx_st                 = vpwph_pkg::VPWPH_TX_SOF;
          s_d.tx_pin                = 1'b1;
          s_d.tx_cnt                = 16'h0000;
          s_d.tx_shift              = s_q.tx_hold;
          s_d.tx_last               = s_q.hold_last;
          s_d.tx_holding_empty_flag = 1'b1;
          s_d.tx_crc                = `VPWPH_CRC_INIT;
          s_d.tx_crc_out            = 1'b0;
          s_d.tx_bits               = 3'd0;
          s_d.append_left           = 2'd0;
        end
      end
      vpwph_pkg::VPWPH_TX_SOF: begin
        if (s_q.tx_cnt == SOF_CYC - 16'h0001) begin
          s_d.tx_st  = vpwph_pkg::VPWPH_TX_BIT;
          s_d.tx_lvl = 1'b0;
          s_d.tx_pin = 1'b0;
          s_d.tx_cnt = 16'h0000;
        end
      end
      vpwph_pkg::VPWPH_TX_BIT: begin
        if (s_q.tx_cnt == tx_dur - 16'h0001) begin
          s_d.tx_lvl = ~s_q.tx_lvl;
          s_d.tx_pin = ~s_q.tx_lvl;
          s_d.tx_cnt = 16'h0000;
          if (s_q.append_left != 2'd0) begin
            s_d.append_left = s_q.append_left - 2'd1;
            if (s_q.append_left == 2'd1) begin
              s_d.tx_st  = vpwph_pkg::VPWPH_TX_OFF;
              s_d.tx_pin = 1'b0;
            end
          end else begin
            s_d.tx_shift = {s_q.tx_shift[6:0], 1'b0};
            s_d.tx_bits  = s_q.tx_bits + 3'd1;
            if (!s_q.tx_crc_out) begin
              s_d.tx_crc = tx_crc_next;
            end
            if (s_q.tx_bits == 3'd7) begin
              if (s_q.tx_crc_out) begin
                // Release after the check byte: the passive gap is EOD
                s_d.tx_st  = vpwph_pkg::VPWPH_TX_OFF;
                s_d.tx_pin = 1'b0;
              end else if (s_q.tx_last || s_q.tx_holding_empty_flag) begin
                s_d.tx_shift   = ~tx_crc_next;
                s_d.tx_crc_out = 1'b1;
              end else begin
                s_d.tx_shift              = s_q.tx_hold;
                s_d.tx_last               = s_q.hold_last;
                s_d.tx_holding_empty_flag = 1'b1;
              end
            end
          end
        end
      end
      vpwph_pkg::VPWPH_TX_HOLD: begin
        s_d.tx_pin = 1'b0;
        if (edge_s) begin
          // Appended ones restart on the winner's bit edge
          s_d.tx_st  = vpwph_pkg::VPWPH_TX_BIT;
          s_d.tx_lvl = rx_line;
          s_d.tx_pin = rx_line;
          s_d.tx_cnt = 16'h0000;
        end else if (bus_idle) begin
          s_d.tx_st = vpwph_pkg::VPWPH_TX_OFF;
        end
      end
      default: begin
        s_d.tx_st  = vpwph_pkg::VPWPH_TX_OFF;
        s_d.tx_pin = 1'b0;
      end
    endcase
    if (mismatch) begin
      s_d.tx_pin = 1'b0;
      s_d.tx_cnt = 16'h0000;
      if (eighth) begin
        s_d.tx_st       = vpwph_pkg::VPWPH_TX_HOLD;
        s_d.append_left = 2'd2;
        s_d.err_loss    = 1'b1;
      end else begin
        s_d.tx_st = vpwph_pkg::VPWPH_TX_OFF;
        if (s_q.append_left == 2'd0) begin
          s_d.err_loss = 1'b1;
        end
      end
    end else if (tx_err) begin
      s_d.tx_st   = vpwph_pkg::VPWPH_TX_OFF;
      s_d.tx_pin  = 1'b0;
      s_d.err_sym = 1'b1;
    end

    s_d.irq = s_d.irq_allow & (s_d.rx_byte_full_flag | s_d.err_sym
                             | s_d.err_crc | s_d.err_loss);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q                       <= '0;
      s_q.tx_st                 <= vpwph_pkg::VPWPH_TX_OFF;
      s_q.tx_holding_empty_flag <= 1'b1;
      s_q.rx_crc                <= `VPWPH_CRC_INIT;
      s_q.tx_crc                <= `VPWPH_CRC_INIT;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata     = s_q.prdata;
  assign pready     = s_q.pready;
  assign pslverr    = s_q.pslverr;
  assign bus_tx_pin = s_q.tx_pin;
  assign irq        = s_q.irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_short_invalid:
    assert property (@(posedge pclk) disable iff (!presetn)
      s_q.in_frame && edge_s && lt_a |=> !s_q.in_frame && s_q.err_sym)
    else $error("short bit did not end the frame");
  a_one_decode:
    assert property (@(posedge pclk) disable iff (!presetn)
      fall_s && !lt_a && lt_b |-> bit_evt && bit_val)
    else $error("active 1 not decoded");
  a_zero_decode:
    assert property (@(posedge pclk) disable iff (!presetn)
      fall_s && !lt_b && lt_c |-> bit_evt && !bit_val)
    else $error("active 0 not decoded");
  a_sof_start:
    assert property (@(posedge pclk) disable iff (!presetn)
      sof_evt |=> s_q.in_frame && s_q.rx_bits == 3'd0)
    else $error("SOF did not open a frame");
  a_break_drop:
    assert property (@(posedge pclk) disable iff (!presetn)
      brk_evt && s_q.in_frame |=> !s_q.in_frame && s_q.err_sym)
    else $error("break not flagged");
  a_defer_busy:
    assert property (@(posedge pclk) disable iff (!presetn)
      s_q.tx_st == vpwph_pkg::VPWPH_TX_DEFER && !bus_idle
      |=> s_q.tx_st == vpwph_pkg::VPWPH_TX_DEFER && !s_q.tx_pin)
    else $error("transmit started on a busy bus");
  a_lose_stop:
    assert property (@(posedge pclk) disable iff (!presetn)
      mismatch && !eighth |=> s_q.tx_st == vpwph_pkg::VPWPH_TX_OFF && !s_q.tx_pin)
    else $error("drive kept after lost arbitration");
  a_append_two:
    assert property (@(posedge pclk) disable iff (!presetn)
      mismatch && eighth |=> s_q.tx_st == vpwph_pkg::VPWPH_TX_HOLD
      && s_q.append_left == 2'd2 && !s_q.tx_pin)
    else $error("eighth-bit loss did not append");
  a_rx_copy:
    assert property (@(posedge pclk) disable iff (!presetn)
      byte_done |=> s_q.rx_byte_full_flag && s_q.rx_hold == $past(rx_next_byte)
      && s_q.irq == s_q.irq_allow)
    else $error("received byte not handed over");
  a_tx_reload:
    assert property (@(posedge pclk) disable iff (!presetn)
      tx_reload |=> s_q.tx_holding_empty_flag && s_q.tx_shift == $past(s_q.tx_hold))
    else $error("shifter not reloaded");
  a_tx_abort:
    assert property (@(posedge pclk) disable iff (!presetn)
      tx_err && !mismatch |=> s_q.tx_st == vpwph_pkg::VPWPH_TX_OFF && s_q.err_sym)
    else $error("transmit error not aborted");
  a_crc_flag:
    assert property (@(posedge pclk) disable iff (!presetn)
      eod_evt && s_q.in_frame && s_q.rx_bits == 3'd0
      && s_q.rx_crc != `VPWPH_CRC_RESIDUE |=> s_q.err_crc && !s_q.in_frame)
    else $error("CRC error not flagged");

endmodule

`default_nettype wire

/* bench/vpwph_bus_node.sv */
// Far-side model: another bus node behind a transceiver, wired-OR bus.
// Assumes active-high levels and symbol times counted in pclk cycles.
`timescale 1ns/10ps
`default_nettype none
module vpwph_bus_node #(
  parameter int SHORT = 64,
  parameter int LONG  = 128,
  parameter int SOF   = 200,
  parameter int IDLE  = 300
) (
  input  wire logic pclk,
  input  wire logic tx_pin,
  output logic      rx_pin
);
  logic drv  = 1'b0;
  logic busy = 1'b0;
  // Active drive from either node wins
  assign rx_pin = drv | tx_pin;
  task automatic sym(input logic lvl, input int n);
    drv <= lvl;
    repeat (n) @(posedge pclk);
  endtask
  // Bits alternate level, first one passive; div gives fourfold rate
  task automatic send(input logic [7:0] b[$], input int div);
    logic l;
    l = 1'b0;
    busy <= 1'b1;
    @(posedge pclk);
    sym(1'b1, SOF / div);
    foreach (b[i]) begin
      for (int k = 7; k >= 0; k--) begin
        sym(l, ((b[i][k] != l) ? LONG : SHORT) / div);
        l = ~l;
      end
    end
    busy <= 1'b0;
    sym(1'b0, IDLE + 20);
  endtask
endmodule
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the VPW protocol handler top.
// Assumes symbol times shortened to one pclk per microsecond.
`timescale 1ns/10ps
`include "vpwph_regs.svh"
`default_nettype none
module testbench;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        bus_rx_pin;
  logic        bus_tx_pin;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  int          mismatches = 0;
  int          checks     = 0;
  always #10 pclk = ~pclk;
  // One pclk per microsecond keeps every frame short
  localparam int CYC_PER_US = 1;
  vpwph_top #(
    .TA_CYC   (16'(`VPWPH_T_A_US * CYC_PER_US)),
    .TB_CYC   (16'(`VPWPH_T_B_US * CYC_PER_US)),
    .TC_CYC   (16'(`VPWPH_T_C_US * CYC_PER_US)),
    .TD_CYC   (16'(`VPWPH_T_D_US * CYC_PER_US)),
    .TE_CYC   (16'(`VPWPH_T_E_US * CYC_PER_US)),
    .IDLE_CYC (16'(`VPWPH_T_IDLE_US * CYC_PER_US)),
    .SHORT_CYC(16'(`VPWPH_T_SHORT_US * CYC_PER_US)),
    .LONG_CYC (16'(`VPWPH_T_LONG_US * CYC_PER_US)),
    .SOF_CYC  (16'(`VPWPH_T_SOF_US * CYC_PER_US)),
    .LOOP_CYC (16'(`VPWPH_T_LOOP_US * CYC_PER_US))
  ) vpwph_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_rx_pin(bus_rx_pin), .bus_tx_pin(bus_tx_pin), .irq(irq));
  vpwph_bus_node vpwph_bus_node_inst (.pclk(pclk), .tx_pin(bus_tx_pin), .rx_pin(bus_rx_pin));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic overrun();
    mismatches++;
    tally_and_finish();
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) overrun();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, `VPWPH_OFS_CTRL1, 32'h0000_0001);
  endtask
  task automatic wait_irq();
    int k;
    repeat (2) @(posedge pclk);
    for (k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge pclk);
    if (irq !== 1'b1) overrun();
  endtask
  function automatic logic [7:0] crc_of(input logic [7:0] b[$]);
    logic [7:0] c;
    c = 8'hFF;
    foreach (b[i])
      for (int k = 7; k >= 0; k--)
        c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i][k]) ? 8'h1D : 8'h00);
    return ~c;
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_rx(input int div, input logic x4, input logic [7:0] flip);
    logic [7:0] f[$];
    logic [7:0] c;
    do_reset();
    apb(1'b1, `VPWPH_OFS_CTRL2, 32'({x4, 1'b0}));
    f = {8'h3C};
    c = crc_of(f) ^ flip;
    f.push_back(c);
    vpwph_bus_node_inst.send(f, div);
    if (div == 4 && !x4) begin
      chk("noise_irq", 32'h0000_0000, 32'(irq));
    end else begin
      chk("rx_irq", 32'h0000_0001, 32'(irq));
      apb(1'b0, `VPWPH_OFS_DATA, 32'h0000_0000);
      chk("rx_last_byte", 32'(c), rd);
      apb(1'b0, `VPWPH_OFS_CODE, 32'h0000_0000);
      chk("rx_code", (flip != 8'h00) ? 32'h0000_0018 : 32'h0000_0008, rd);
    end
  endtask
  // SOF, a passive zero, then an active pulse of n cycles
  task automatic s_err(input int n);
    do_reset();
    vpwph_bus_node_inst.sym(1'b1, 200);
    vpwph_bus_node_inst.sym(1'b0, 64);
    vpwph_bus_node_inst.sym(1'b1, n);
    vpwph_bus_node_inst.sym(1'b0, 320);
    apb(1'b0, `VPWPH_OFS_CODE, 32'h0000_0000);
    chk("sym_code", 32'h0000_001C, rd);
    repeat (2) @(posedge pclk);
    chk("irq_cleared", 32'h0000_0000, 32'(irq));
  endtask
  task automatic s_tx();
    logic [7:0] q[$];
    int         k;
    q = {8'hA5, 8'h5A};
    do_reset();
    apb(1'b1, `VPWPH_OFS_CTRL2, 32'h0000_0001);
    apb(1'b1, `VPWPH_OFS_DATA, 32'h0000_00A5);
    // Second byte only once the holding register is free
    for (k = 0; k < 200; k++) begin
      apb(1'b0, `VPWPH_OFS_STATUS, 32'h0000_0000);
      if (rd[1]) break;
    end
    chk("tx_empty_wait", 32'h0000_0001, 32'(rd[1]));
    apb(1'b1, `VPWPH_OFS_DATA, 32'h0000_015A);
    wait_irq();
    apb(1'b0, `VPWPH_OFS_STATUS, 32'h0000_0000);
    chk("tx_empty", 32'h0000_0001, 32'(rd[1]));
    apb(1'b0, `VPWPH_OFS_DATA, 32'h0000_0000);
    chk("loop_byte", 32'h0000_00A5, rd);
    wait_irq();
    apb(1'b0, `VPWPH_OFS_DATA, 32'h0000_0000);
    chk("loop_byte2", 32'h0000_005A, rd);
    wait_irq();
    apb(1'b0, `VPWPH_OFS_DATA, 32'h0000_0000);
    chk("loop_crc", 32'(crc_of(q)), rd);
  endtask
  // Own frame against the other node's zero byte, both starting together
  task automatic s_arb(input logic [7:0] mine);
    logic [7:0] f[$];
    int         k;
    do_reset();
    f = {8'h00};
    f.push_back(crc_of(f));
    apb(1'b1, `VPWPH_OFS_DATA, 32'h0000_0100 | 32'(mine));
    for (k = 0; k < 1000 && bus_tx_pin !== 1'b1; k++) @(posedge pclk);
    if (bus_tx_pin !== 1'b1) overrun();
    vpwph_bus_node_inst.send(f, 1);
    chk("arb_released", 32'h0000_0000, 32'(bus_tx_pin));
    apb(1'b0, `VPWPH_OFS_CODE, 32'h0000_0000);
    chk("arb_code", 32'h0000_0014, rd);
    // Appended ones must leave the winner's frame clean
    apb(1'b0, `VPWPH_OFS_CODE, 32'h0000_0000);
    chk("arb_frame_intact", 32'h0000_000C, rd);
  endtask
  // Own byte written while the other node holds a frame on the bus
  task automatic s_defer();
    logic [7:0] f[$];
    logic       seen;
    int         k;
    do_reset();
    f = {8'h00};
    f.push_back(crc_of(f));
    seen = 1'b0;
    fork
      vpwph_bus_node_inst.send(f, 1);
      begin
        repeat (300) @(posedge pclk);
        apb(1'b1, `VPWPH_OFS_DATA, 32'h0000_01FF);
        while (vpwph_bus_node_inst.busy) begin
          @(posedge pclk);
          seen |= bus_tx_pin;
        end
        chk("deferred", 32'h0000_0000, 32'(seen));
        for (k = 0; k < 1000 && bus_tx_pin !== 1'b1; k++) @(posedge pclk);
        if (bus_tx_pin !== 1'b1) overrun();
        for (k = 0; k < 1000 && bus_tx_pin === 1'b1; k++) @(posedge pclk);
        chk("sof_len", 32'd200, 32'(k));
      end
    join
  endtask
  initial begin
    do_reset();
    apb(1'b0, `VPWPH_OFS_CODE, 32'h0000_0000);
    chk("reset_code", 32'h0000_0008, rd);
    apb(1'b0, 12'hFFC, 32'h0000_0000);
    chk("unmapped_err", 32'h0000_0001, 32'(er));
    s_rx(1, 1'b0, 8'h00);
    s_rx(1, 1'b0, 8'h01);
    s_rx(4, 1'b1, 8'h00);
    s_rx(4, 1'b0, 8'h00);
    s_err(10);
    s_err(300);
    s_tx();
    s_arb(8'hFF);
    s_arb(8'h01);
    s_defer();
    tally_and_finish();
  end
endmodule
`default_nettype wire
